//--- core/rdim_consts.svh
`ifndef RDIM_CONSTS_SVH
`define RDIM_CONSTS_SVH

// ==========================================================
// Register offsets
`define RDIM_ADDR_EVENT_EN     7'h03
`define RDIM_ADDR_EVENT_STAT   7'h04
`define RDIM_ADDR_FSC_LOW      7'h06
`define RDIM_ADDR_FSC_HIGH     7'h07
`define RDIM_ADDR_SWITCH_MODE  7'h08
`define RDIM_ADDR_CLK_PHASE    7'h0C
`define RDIM_ADDR_SYNC_PHASE   7'h0D
`define RDIM_ADDR_RX_SYNC_CFG  7'h10

// ==========================================================
// Reset values
`define RDIM_RST_EVENT_EN      6'h00
`define RDIM_RST_FSC_LOW       8'h00
`define RDIM_RST_FSC_HIGH      2'h2
`define RDIM_RST_SLEEP         1'h0
`define RDIM_RST_SWITCH_MODE   2'h0
`define RDIM_RST_LOOP          1'h1

// ==========================================================
// Field positions
`define RDIM_BIT_SLEEP         7
`define RDIM_BIT_CLK_EARLY     2
`define RDIM_BIT_CLK_LATE      0
`define RDIM_BIT_SYNC_PH90     5
`define RDIM_BIT_SYNC_PH0      4
`define RDIM_BIT_SYNC_CLR      7
`define RDIM_BIT_SYNC_LOOP     6
`define RDIM_BIT_SYNC_ROLE     5
`define RDIM_BIT_SYNC_EN       4
`define RDIM_BIT_RX_CLR        2
`define RDIM_BIT_RX_LOOP       1
`define RDIM_BIT_RX_EN         0
`define RDIM_CTRL_RX           0
`define RDIM_CTRL_DUTY         1
`define RDIM_CTRL_SYNC         2

// ==========================================================
// Serial frame
`define RDIM_INSTR_LAST        4'h7
`define RDIM_DATA_LAST         4'hF
`define RDIM_DATA_FIRST        4'h8
`define RDIM_BIT_READ          7

`endif

//--- core/rdim_pkg.sv
package rdim_pkg;
	typedef enum logic [1:0] {
		RDIM_PH_INSTR = 2'b00,
		RDIM_PH_WDATA = 2'b01,
		RDIM_PH_RDATA = 2'b10,
		RDIM_PH_DONE  = 2'b11
	} rdim_phase_t;
endpackage

//--- core/rdim_regs.sv
`timescale 1ns/1ps
`include "rdim_consts.svh"
module rdim_regs #(
	parameter int P_ADDR_W = 7
) (
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_soft_rst,
	input  wire logic       i_spi_sclk,
	input  wire logic       i_spi_cs_n,
	input  wire logic       i_spi_sdi,
	output logic            o_spi_sdo,
	output logic            o_spi_sdo_oe,
	input  wire logic       i_sync_locked,
	input  wire logic       i_duty_locked,
	input  wire logic       i_receiver_locked,
	input  wire logic       i_clock_early_phase_flag,
	input  wire logic       i_clock_late_phase_flag,
	input  wire logic       i_sync_zero_phase_flag,
	input  wire logic       i_sync_quadrature_phase_flag,
	output logic [9:0]      o_fullscale_current_code,
	output logic            o_sleep,
	output logic [1:0]      o_output_switch_mode,
	output logic            o_sync_auto_relock,
	output logic            o_sync_role_select,
	output logic            o_sync_controller_enable,
	output logic            o_receiver_auto_relock,
	output logic            o_receiver_controller_enable,
	output logic            o_sync_search_restart,
	output logic            o_receiver_search_restart,
	output logic            o_irq
);

	if (P_ADDR_W != 7) begin : g_addr_w_chk
		$error("rdim_regs: address width must be 7");
	end

	// ==========================================================
	// Serial port
	logic                   sclk_q_r;
	logic [3:0]             bit_cnt_r;
	logic [6:0]             shift_in_r;
	logic [P_ADDR_W-1:0]    addr_r;
	logic [7:0]             sdo_r;
	rdim_pkg::rdim_phase_t  phase_r;
	logic                   sclk_rise;
	logic                   sclk_fall;
	logic [7:0]             frame_byte;
	logic                   wr_stb;
	logic [7:0]             rd_data;

	assign sclk_rise  = i_spi_sclk & ~sclk_q_r;
	assign sclk_fall  = ~i_spi_sclk & sclk_q_r;
	assign frame_byte = {shift_in_r, i_spi_sdi};
	assign wr_stb     = ~i_spi_cs_n & sclk_rise
		& (phase_r == rdim_pkg::RDIM_PH_WDATA)
		& (bit_cnt_r == `RDIM_DATA_LAST);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			sclk_q_r <= 1'b0;
		else
			sclk_q_r <= i_spi_sclk;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			bit_cnt_r  <= 4'h0;
			shift_in_r <= 7'h00;
			addr_r     <= 7'h00;
			phase_r    <= rdim_pkg::RDIM_PH_INSTR;
		end else if (i_spi_cs_n) begin
			bit_cnt_r <= 4'h0;
			phase_r   <= rdim_pkg::RDIM_PH_INSTR;
		end else if (sclk_rise) begin
			shift_in_r <= frame_byte[6:0];
			bit_cnt_r  <= bit_cnt_r + 4'h1;
			unique case (phase_r)
				rdim_pkg::RDIM_PH_INSTR: begin
					if (bit_cnt_r == `RDIM_INSTR_LAST) begin
						addr_r  <= frame_byte[P_ADDR_W-1:0];
						phase_r <= frame_byte[`RDIM_BIT_READ]
							? rdim_pkg::RDIM_PH_RDATA
							: rdim_pkg::RDIM_PH_WDATA;
					end
				end
				rdim_pkg::RDIM_PH_WDATA,
				rdim_pkg::RDIM_PH_RDATA: begin
					if (bit_cnt_r == `RDIM_DATA_LAST)
						phase_r <= rdim_pkg::RDIM_PH_DONE;
				end
				rdim_pkg::RDIM_PH_DONE: begin
					bit_cnt_r <= bit_cnt_r;
				end
			endcase
		end
	end

	// Read data loaded at end of instruction, shifted on falling edges
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sdo_r        <= 8'h00;
			o_spi_sdo_oe <= 1'b0;
		end else if (i_spi_cs_n) begin
			o_spi_sdo_oe <= 1'b0;
		end else if (sclk_rise && phase_r == rdim_pkg::RDIM_PH_INSTR
				&& bit_cnt_r == `RDIM_INSTR_LAST
				&& frame_byte[`RDIM_BIT_READ]) begin
			sdo_r        <= rd_data;
			o_spi_sdo_oe <= 1'b1;
		// Hold bit 7 over the fall that ends the instruction byte
		end else if (sclk_fall && phase_r == rdim_pkg::RDIM_PH_RDATA
				&& bit_cnt_r != `RDIM_DATA_FIRST) begin
			sdo_r <= {sdo_r[6:0], 1'b0};
		end else if (phase_r == rdim_pkg::RDIM_PH_DONE) begin
			o_spi_sdo_oe <= 1'b0;
		end
	end

	assign o_spi_sdo = sdo_r[7];

	// ==========================================================
	// Configuration registers
	logic [5:0] event_en_r;
	logic [7:0] fsc_low_r;
	logic [1:0] fsc_high_r;
	logic       sleep_r;
	logic [1:0] switch_mode_r;
	logic       sync_clear_r;
	logic       sync_loop_r;
	logic       sync_role_r;
	logic       sync_en_r;
	logic       rx_clear_r;
	logic       rx_loop_r;
	logic       rx_en_r;
	logic [7:0] wr_data;
	logic [P_ADDR_W-1:0] wr_addr;

	assign wr_data = frame_byte;
	assign wr_addr = addr_r;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			event_en_r <= `RDIM_RST_EVENT_EN;
		end else if (i_soft_rst) begin
			event_en_r <= `RDIM_RST_EVENT_EN;
		end else if (wr_stb && wr_addr == `RDIM_ADDR_EVENT_EN) begin
			event_en_r <= wr_data[5:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fsc_low_r     <= `RDIM_RST_FSC_LOW;
			fsc_high_r    <= `RDIM_RST_FSC_HIGH;
			sleep_r       <= `RDIM_RST_SLEEP;
			switch_mode_r <= `RDIM_RST_SWITCH_MODE;
		end else if (i_soft_rst) begin
			fsc_low_r     <= `RDIM_RST_FSC_LOW;
			fsc_high_r    <= `RDIM_RST_FSC_HIGH;
			sleep_r       <= `RDIM_RST_SLEEP;
			switch_mode_r <= `RDIM_RST_SWITCH_MODE;
		end else if (wr_stb) begin
			if (wr_addr == `RDIM_ADDR_FSC_LOW)
				fsc_low_r <= wr_data;
			if (wr_addr == `RDIM_ADDR_FSC_HIGH) begin
				fsc_high_r <= wr_data[1:0];
				sleep_r    <= wr_data[`RDIM_BIT_SLEEP];
			end
			// Code 3 is kept as written; the converter decides its meaning
			if (wr_addr == `RDIM_ADDR_SWITCH_MODE)
				switch_mode_r <= wr_data[1:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync_clear_r <= 1'b0;
			sync_loop_r  <= `RDIM_RST_LOOP;
			sync_role_r  <= 1'b0;
			sync_en_r    <= 1'b0;
			rx_clear_r   <= 1'b0;
			rx_loop_r    <= `RDIM_RST_LOOP;
			rx_en_r      <= 1'b0;
		end else if (i_soft_rst) begin
			sync_clear_r <= 1'b0;
			sync_loop_r  <= `RDIM_RST_LOOP;
			sync_role_r  <= 1'b0;
			sync_en_r    <= 1'b0;
			rx_clear_r   <= 1'b0;
			rx_loop_r    <= `RDIM_RST_LOOP;
			rx_en_r      <= 1'b0;
		end else if (wr_stb && wr_addr == `RDIM_ADDR_RX_SYNC_CFG) begin
			sync_clear_r <= wr_data[`RDIM_BIT_SYNC_CLR];
			sync_loop_r  <= wr_data[`RDIM_BIT_SYNC_LOOP];
			sync_role_r  <= wr_data[`RDIM_BIT_SYNC_ROLE];
			sync_en_r    <= wr_data[`RDIM_BIT_SYNC_EN];
			rx_clear_r   <= wr_data[`RDIM_BIT_RX_CLR];
			rx_loop_r    <= wr_data[`RDIM_BIT_RX_LOOP];
			rx_en_r      <= wr_data[`RDIM_BIT_RX_EN];
		end
	end

	// ==========================================================
	// Lock event flags
	logic [2:0] locked;
	logic [2:0] locked_q_r;
	logic [2:0] lost_evt;
	logic [2:0] ctrl_clear;
	logic [5:0] status_r;

	assign locked     = {i_sync_locked, i_duty_locked, i_receiver_locked};
	assign lost_evt   = locked_q_r & ~locked;
	// Duty controller has no flag clear of its own
	assign ctrl_clear = {sync_clear_r, 1'b0, rx_clear_r};

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			locked_q_r <= 3'h0;
		else
			locked_q_r <= locked;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			status_r <= 6'h00;
		end else if (i_soft_rst) begin
			status_r <= 6'h00;
		end else begin
			for (int c = 0; c < 3; c++) begin
				// Lock flag follows the lock level while enabled
				status_r[2*c] <= event_en_r[2*c] & locked[c];
				// Loss flag is sticky; a new loss beats a clear
				if (!event_en_r[2*c+1])
					status_r[2*c+1] <= 1'b0;
				else if (lost_evt[c])
					status_r[2*c+1] <= 1'b1;
				else if (ctrl_clear[c])
					status_r[2*c+1] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_sync_search_restart     <= 1'b0;
			o_receiver_search_restart <= 1'b0;
			o_irq                     <= 1'b0;
		end else begin
			o_sync_search_restart <= sync_en_r & sync_loop_r
				& lost_evt[`RDIM_CTRL_SYNC];
			o_receiver_search_restart <= rx_en_r & rx_loop_r
				& lost_evt[`RDIM_CTRL_RX];
			o_irq <= |status_r;
		end
	end

	// ==========================================================
	// Readback; write-only bits and unmapped offsets read zero
	always_comb begin
		rd_data = 8'h00;
		unique case (frame_byte[P_ADDR_W-1:0])
			`RDIM_ADDR_EVENT_STAT:  rd_data = {2'h0, status_r};
			`RDIM_ADDR_FSC_LOW:     rd_data = fsc_low_r;
			`RDIM_ADDR_FSC_HIGH:    rd_data = {sleep_r, 5'h00, fsc_high_r};
			`RDIM_ADDR_SWITCH_MODE: rd_data = {6'h00, switch_mode_r};
			`RDIM_ADDR_CLK_PHASE: begin
				rd_data[`RDIM_BIT_CLK_EARLY] = i_clock_early_phase_flag;
				rd_data[`RDIM_BIT_CLK_LATE]  = i_clock_late_phase_flag;
			end
			`RDIM_ADDR_SYNC_PHASE: begin
				rd_data[`RDIM_BIT_SYNC_PH0]  = i_sync_zero_phase_flag;
				rd_data[`RDIM_BIT_SYNC_PH90] = i_sync_quadrature_phase_flag;
			end
			`RDIM_ADDR_RX_SYNC_CFG: begin
				rd_data[`RDIM_BIT_SYNC_LOOP] = sync_loop_r;
				rd_data[`RDIM_BIT_SYNC_ROLE] = sync_role_r;
				rd_data[`RDIM_BIT_SYNC_EN]   = sync_en_r;
				rd_data[`RDIM_BIT_RX_LOOP]   = rx_loop_r;
				rd_data[`RDIM_BIT_RX_EN]     = rx_en_r;
			end
			default: rd_data = 8'h00;
		endcase
	end

	// ==========================================================
	// Outputs
	assign o_fullscale_current_code     = {fsc_high_r, fsc_low_r};
	assign o_sleep                      = sleep_r;
	assign o_output_switch_mode         = switch_mode_r;
	assign o_sync_auto_relock           = sync_loop_r;
	assign o_sync_role_select           = sync_role_r;
	assign o_sync_controller_enable     = sync_en_r;
	assign o_receiver_auto_relock       = rx_loop_r;
	assign o_receiver_controller_enable = rx_en_r;

endmodule // rdim_regs

//--- verification/rdim_regs_props.sv
`timescale 1ns/1ps
module rdim_regs_props (
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_soft_rst,
	input  wire logic       i_spi_cs_n,
	input  wire logic       o_spi_sdo_oe,
	input  wire logic [9:0] o_fullscale_current_code,
	input  wire logic       o_sleep,
	input  wire logic [1:0] o_output_switch_mode,
	input  wire logic       o_sync_auto_relock,
	input  wire logic       o_receiver_auto_relock,
	input  wire logic       o_sync_search_restart,
	input  wire logic       o_receiver_search_restart,
	input  wire logic       o_irq
);
	// ==========================================================
	// Port-level checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_reset_code_value: assert property ($fell(i_sys_rst) |->
		o_fullscale_current_code == 10'h200 && !o_sleep &&
		o_output_switch_mode == 2'h0)
		else $error("code, sleep or mode wrong after reset");
	a_reset_loop_on: assert property ($fell(i_sys_rst) |->
		o_sync_auto_relock && o_receiver_auto_relock)
		else $error("loop bits not set after reset");
	a_soft_defaults: assert property (i_soft_rst ##1 i_soft_rst |=>
		o_fullscale_current_code == 10'h200 && !o_sleep && !o_irq)
		else $error("soft reset left state behind");
	// Idle bus must never move configuration except through soft reset
	a_cfg_quiet: assert property (i_spi_cs_n && $past(i_spi_cs_n) &&
		!$past(i_soft_rst) |-> $stable(o_fullscale_current_code) &&
		$stable(o_sleep) && $stable(o_output_switch_mode))
		else $error("configuration changed with no frame");
	a_oe_drop: assert property ($rose(i_spi_cs_n) |=> !o_spi_sdo_oe)
		else $error("read driver kept on after deselect");
	a_oe_needs_cs: assert property ($rose(o_spi_sdo_oe) |->
		!i_spi_cs_n && !$past(i_spi_cs_n))
		else $error("read driver on without select");
	a_sync_restart: assert property (o_sync_search_restart |->
		o_sync_auto_relock ##1 !o_sync_search_restart)
		else $error("sync restart pulse wrong");
	a_rx_restart: assert property (o_receiver_search_restart |->
		o_receiver_auto_relock ##1 !o_receiver_search_restart)
		else $error("receiver restart pulse wrong");
endmodule // rdim_regs_props

bind rdim_regs rdim_regs_props i_rdim_regs_props (.i_clk, .i_sys_rst,
	.i_soft_rst, .i_spi_cs_n, .o_spi_sdo_oe, .o_fullscale_current_code,
	.o_sleep, .o_output_switch_mode, .o_sync_auto_relock,
	.o_receiver_auto_relock, .o_sync_search_restart,
	.o_receiver_search_restart, .o_irq);

//--- verification/tb_top.sv
`timescale 1ns/1ps
`include "rdim_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	n_mismatch++; $display("MISMATCH t=%0t got=%0h exp=%0h", \
	$time, (g), (e)); end end
module tb_top;
	logic       i_clk, i_sys_rst, i_soft_rst, i_spi_sclk, i_spi_cs_n;
	logic       i_spi_sdi, o_spi_sdo, o_spi_sdo_oe, o_sleep, o_irq;
	logic       i_sync_locked, i_duty_locked, i_receiver_locked;
	logic       i_clock_early_phase_flag, i_clock_late_phase_flag;
	logic       i_sync_zero_phase_flag, i_sync_quadrature_phase_flag;
	logic [9:0] o_fullscale_current_code;
	logic [1:0] o_output_switch_mode;
	logic       o_sync_auto_relock, o_sync_role_select;
	logic       o_sync_controller_enable, o_receiver_auto_relock;
	logic       o_receiver_controller_enable, o_sync_search_restart;
	logic       o_receiver_search_restart;
	logic [7:0] rd_v;
	int         n_mismatch, check_count, cyc, n_p;

	rdim_regs i_rdim_regs (.i_clk, .i_sys_rst, .i_soft_rst, .i_spi_sclk,
		.i_spi_cs_n, .i_spi_sdi, .o_spi_sdo, .o_spi_sdo_oe, .i_sync_locked,
		.i_duty_locked, .i_receiver_locked, .i_clock_early_phase_flag,
		.i_clock_late_phase_flag, .i_sync_zero_phase_flag,
		.i_sync_quadrature_phase_flag, .o_fullscale_current_code, .o_sleep,
		.o_output_switch_mode, .o_sync_auto_relock, .o_sync_role_select,
		.o_sync_controller_enable, .o_receiver_auto_relock,
		.o_receiver_controller_enable, .o_sync_search_restart,
		.o_receiver_search_restart, .o_irq);

	// ==========================================================
	// Serial frame: three cycles per sclk phase, above the one needed
	task automatic xfer(input logic [7:0] ins, input logic [7:0] wd);
		logic [15:0] f;
		f = {ins, wd};
		i_spi_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			i_spi_sdi = f[i];
			repeat (3) @(negedge i_clk);
			i_spi_sclk = 1'b1;
			if (i < 8) rd_v[i] = o_spi_sdo;
			repeat (3) @(negedge i_clk);
			i_spi_sclk = 1'b0;
		end
		repeat (3) @(negedge i_clk);
		i_spi_cs_n = 1'b1;
		repeat (3) @(negedge i_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		xfer({1'b0, a}, d);
	endtask
	task automatic rd(input logic [6:0] a);
		xfer({1'b1, a}, 8'h00);
	endtask
	task automatic cnt(input logic sy);
		n_p = 0;
		repeat (8) begin
			@(negedge i_clk);
			n_p += sy ? o_sync_search_restart : o_receiver_search_restart;
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		`CHK(o_fullscale_current_code, 10'h200)
		`CHK(o_sleep, 1'b0)
		rd(`RDIM_ADDR_FSC_HIGH);
		`CHK(rd_v, 8'h02)
		rd(`RDIM_ADDR_RX_SYNC_CFG);
		`CHK(rd_v, 8'h42)
		rd(`RDIM_ADDR_EVENT_EN);
		`CHK(rd_v, 8'h00)
		rd(7'h05);
		`CHK(rd_v, 8'h00)
	endtask
	task automatic t_fsc;
		wr(`RDIM_ADDR_FSC_LOW, 8'hFF);
		wr(`RDIM_ADDR_FSC_HIGH, 8'h83);
		`CHK(o_fullscale_current_code, 10'h3FF)
		`CHK(o_sleep, 1'b1)
		rd(`RDIM_ADDR_FSC_HIGH);
		`CHK(rd_v, 8'h83)
		wr(`RDIM_ADDR_FSC_HIGH, 8'h01);
		`CHK(o_fullscale_current_code, 10'h1FF)
		`CHK(o_sleep, 1'b0)
		i_soft_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_soft_rst = 1'b0;
		@(negedge i_clk);
		`CHK(o_fullscale_current_code, 10'h200)
	endtask
	task automatic t_mode;
		for (int v = 0; v < 3; v++) begin
			wr(`RDIM_ADDR_SWITCH_MODE, 8'(v));
			`CHK(o_output_switch_mode, 2'(v))
			rd(`RDIM_ADDR_SWITCH_MODE);
			`CHK(rd_v, 8'(v))
		end
	endtask
	task automatic t_phase;
		for (int i = 0; i < 4; i++) begin
			{i_clock_early_phase_flag, i_clock_late_phase_flag} = 2'(i);
			{i_sync_zero_phase_flag, i_sync_quadrature_phase_flag} = 2'(i);
			rd(`RDIM_ADDR_CLK_PHASE);
			`CHK(rd_v, {5'h00, i[1], 1'b0, i[0]})
			rd(`RDIM_ADDR_SYNC_PHASE);
			`CHK(rd_v, {2'h0, i[0], i[1], 4'h0})
		end
	endtask
	task automatic t_cfg;
		wr(`RDIM_ADDR_RX_SYNC_CFG, 8'h31);
		`CHK({o_sync_auto_relock, o_sync_role_select, o_sync_controller_enable,
			o_receiver_auto_relock, o_receiver_controller_enable},
			5'b01101)
		rd(`RDIM_ADDR_RX_SYNC_CFG);
		`CHK(rd_v, 8'h31)
		// Master with both loops on and both controllers running
		wr(`RDIM_ADDR_RX_SYNC_CFG, 8'h73);
	endtask
	task automatic t_flags;
		wr(`RDIM_ADDR_EVENT_EN, 8'h3F);
		rd(`RDIM_ADDR_EVENT_STAT);
		`CHK(rd_v, 8'h15)
		`CHK(o_irq, 1'b1)
		i_receiver_locked = 1'b0;
		cnt(1'b0);
		`CHK(n_p, 1)
		rd(`RDIM_ADDR_EVENT_STAT);
		`CHK(rd_v, 8'h16)
		wr(`RDIM_ADDR_RX_SYNC_CFG, 8'h77);
		wr(`RDIM_ADDR_RX_SYNC_CFG, 8'h73);
		rd(`RDIM_ADDR_EVENT_STAT);
		`CHK(rd_v, 8'h14)
		i_sync_locked = 1'b0;
		cnt(1'b1);
		`CHK(n_p, 1)
		rd(`RDIM_ADDR_EVENT_STAT);
		`CHK(rd_v, 8'h24)
		wr(`RDIM_ADDR_RX_SYNC_CFG, 8'hF3);
		wr(`RDIM_ADDR_RX_SYNC_CFG, 8'h73);
		i_duty_locked = 1'b0;
		rd(`RDIM_ADDR_EVENT_STAT);
		`CHK(rd_v, 8'h08)
		wr(`RDIM_ADDR_EVENT_EN, 8'h00);
		rd(`RDIM_ADDR_EVENT_STAT);
		`CHK(rd_v, 8'h00)
		`CHK(o_irq, 1'b0)
		wr(`RDIM_ADDR_EVENT_EN, 8'h3F);
		i_receiver_locked = 1'b1;
		rd(`RDIM_ADDR_EVENT_STAT);
		`CHK(rd_v, 8'h01)
		`CHK(o_irq, 1'b1)
	endtask

	// ==========================================================
	// Run control
	task automatic report_and_stop;
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// Far beyond the roughly 4000 cycles that the frames take
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop;
		end
	end
	initial begin
		{i_sys_rst, i_spi_cs_n} = 2'b11;
		{i_soft_rst, i_spi_sclk, i_spi_sdi} = 3'b000;
		{i_sync_locked, i_duty_locked, i_receiver_locked} = 3'b111;
		{i_clock_early_phase_flag, i_clock_late_phase_flag} = 2'b00;
		{i_sync_zero_phase_flag, i_sync_quadrature_phase_flag} = 2'b00;
		repeat (3) @(negedge i_clk);
		i_sys_rst = 1'b0;
		repeat (2) @(negedge i_clk);
		t_reset;
		t_fsc;
		t_mode;
		t_phase;
		t_cfg;
		t_flags;
		report_and_stop;
	end
endmodule // tb_top
